// ==== hw/ssp_pkg.sv ====
// constants, field layouts and carrier types of the spi port
// assumes one 25 mhz clock and a byte-wide register port
package ssp_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] SSP_OFS_BUF   = 3'h0;
   localparam logic [2:0] SSP_OFS_CON1  = 3'h1;
   localparam logic [2:0] SSP_OFS_CON3  = 3'h2;
   localparam logic [2:0] SSP_OFS_STAT  = 3'h3;
   localparam logic [2:0] SSP_OFS_PERIPHERAL_IRQ_ENABLE_ONE  = 3'h4;
   localparam logic [2:0] SSP_OFS_PERIPHERAL_IRQ_FLAGS_ONE  = 3'h5;
   localparam logic [2:0] SSP_OFS_BAUD  = 3'h6;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SSP_CON1_WRITE_COLLISION_FLAG = 7;
   localparam int SSP_CON1_OV   = 6;
   localparam int SSP_CON1_EN   = 5;
   localparam int SSP_CON1_CKP  = 4;
   localparam int SSP_CON3_BUFFER_OVERWRITE_ENABLE = 4;
   localparam int SSP_STAT_SMP  = 7;
   localparam int SSP_STAT_CKE  = 6;
   localparam int SSP_STAT_BF   = 0;
   localparam int SSP_PIR_FLAG  = 3;
   localparam int SSP_PIE_EN    = 3;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SSP_RST_BYTE = 8'h00;
   // ----------------------------------------------------------------
   // mode field codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SSP_MODE_DIV4   = 4'h0;
   localparam logic [3:0] SSP_MODE_DIV16  = 4'h1;
   localparam logic [3:0] SSP_MODE_DIV64  = 4'h2;
   localparam logic [3:0] SSP_MODE_TMR2   = 4'h3;
   localparam logic [3:0] SSP_MODE_SLV_SS = 4'h4;
   localparam logic [3:0] SSP_MODE_SLV    = 4'h5;
   localparam logic [3:0] SSP_MODE_BAUD   = 4'ha;
   // ----------------------------------------------------------------
   // timing: system clock cycles per serial clock half period, then the last edge index and the last bit index
   // ----------------------------------------------------------------
   localparam logic [9:0] SSP_HALF_DIV4  = 10'h002;
   localparam logic [9:0] SSP_HALF_DIV16 = 10'h008;
   localparam logic [9:0] SSP_HALF_DIV64 = 10'h020;
   localparam logic [3:0] SSP_EDGES      = 4'hf;
   localparam logic [3:0] SSP_LAST_BIT   = 4'h7;
   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ssp_bus_req_t;

   typedef enum logic {SSP_MS_IDLE, SSP_MS_RUN} ssp_mst_t;
endpackage

// ==== hw/ssp_rate_gen.sv ====
// serial clock half-period tick generator for master mode
// assumes the timer tick input is a one-cycle pulse in the mclk domain
`timescale 1ns/1ps
module ssp_rate_gen (
   input  wire logic       mclk_i,      // system clock
   input  wire logic       reset_i,     // sync reset
   input  wire logic       ce_i,        // clock enable
   input  wire logic       run_i,       // count while high
   input  wire logic [3:0] mode_i,      // port mode field
   input  wire logic [7:0] baud_i,      // baud divider value
   input  wire logic       tmr2_tick_i, // timer output pulse
   output logic            tick_o       // half-period tick
);
   import ssp_pkg::*;

   logic [9:0] cnt_ff;
   logic [9:0] half_len;

   function automatic logic [9:0] half_of(input logic [3:0] m, input logic [7:0] b);
      if (m == SSP_MODE_DIV16)
         half_of = SSP_HALF_DIV16;
      else if (m == SSP_MODE_DIV64)
         half_of = SSP_HALF_DIV64;
      else if (m == SSP_MODE_BAUD)
         half_of = {1'b0, b, 1'b0} + 10'h002;
      else
         half_of = SSP_HALF_DIV4;
   endfunction

   assign half_len = half_of(mode_i, baud_i);
   // timer mode toggles the clock once per timer pulse: period is two pulses
   assign tick_o = run_i && ((mode_i == SSP_MODE_TMR2) ? tmr2_tick_i
                                                      : (cnt_ff == half_len - 10'h001));

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         cnt_ff <= 10'h000;
      else if (ce_i) begin
         if (!run_i || tick_o)
            cnt_ff <= 10'h000;
         else
            cnt_ff <= cnt_ff + 10'h001;
      end
   end
endmodule // ssp_rate_gen

// ==== hw/ssp_shifter.sv ====
// eight-bit shift register with bit counter and output latch
// assumes the caller issues at most one of load, drive, sample per cycle
`timescale 1ns/1ps
module ssp_shifter (
   input  wire logic       mclk_i,   // system clock
   input  wire logic       reset_i,  // sync reset
   input  wire logic       ce_i,     // clock enable
   input  wire logic       clr_i,    // port reset: counter to zero
   input  wire logic       load_i,   // load new byte
   input  wire logic [7:0] ld_data_i,// byte to load
   input  wire logic       drive_i,  // present next bit
   input  wire logic       sample_i, // latch serial input
   input  wire logic       sdi_i,    // serial data in
   output logic [7:0]      sr_o,     // shift register
   output logic            out_o,    // bit on the data output
   output logic [3:0]      cnt_o,    // bits taken this byte
   output logic            done_o    // last bit latched
);
   import ssp_pkg::*;

   assign done_o = sample_i && (cnt_o == SSP_LAST_BIT);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sr_o  <= SSP_RST_BYTE;
         out_o <= 1'b0;
      end else if (ce_i) begin
         if (load_i) begin
            sr_o  <= ld_data_i;
            out_o <= ld_data_i[7];
         end else if (sample_i)
            sr_o  <= {sr_o[6:0], sdi_i};
         else if (drive_i)
            out_o <= sr_o[7];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         cnt_o <= 4'h0;
      else if (ce_i) begin
         if (clr_i || load_i || done_o)
            cnt_o <= 4'h0;
         else if (sample_i)
            cnt_o <= cnt_o + 4'h1;
      end
   end
endmodule // ssp_shifter

// ==== hw/ssp_spi_port.sv ====
// spi function of a synchronous serial port: registers, master clocking,
// slave edge detection, receive buffer and flags
// assumes all pins are synchronous to mclk_i and the slave clock is slow
// enough that every level lasts at least two mclk cycles
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ssp_spi_port (
   input  wire logic                  mclk_i,      // system clock
   input  wire logic                  reset_i,     // sync reset, active high
   input  wire logic                  ce_i,        // clock enable
   input  wire ssp_pkg::ssp_bus_req_t bus_i,       // register request
   output logic [7:0]                 rdata_o,     // read data, cycle after
   input  wire logic                  sleep_i,     // device is asleep
   input  wire logic                  idle_i,      // device is idle
   input  wire logic                  tmr2_tick_i, // timer output pulse
   input  wire logic                  sck_i,       // serial clock pin in
   output logic                       sck_o,       // serial clock pin out
   output logic                       sck_oe_o,    // serial clock drive
   input  wire logic                  sdi_i,       // serial data in
   output logic                       sdo_o,       // serial data out
   output logic                       sdo_oe_o,    // serial data drive
   input  wire logic                  ss_n_i,      // slave select, low active
   output logic                       port_irq_o,  // flag and enable
   output logic                       wake_o       // wake request
);
   import ssp_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] buf_ff;
   logic       write_collision_flag_ff, ov_ff, en_ff, ckp_ff;
   logic [3:0] mode_ff;
   logic       buffer_overwrite_enable_ff, smp_ff, cke_ff, bf_ff, flag_ff, ie_ff;
   logic [7:0] baud_ff;
   logic [7:0] con3_ff;
   logic       sck_prev_ff;
   ssp_mst_t   mst_ff;
   logic [3:0] edge_ff;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic is_master, is_slave, ss_mode, slv_act, busy;
   logic wr_buf, rd_buf, accept, collide;
   logic tick, lead_m, trail_m, lead_s, trail_s, lead, trail;
   logic do_drive, do_sample, port_clr;
   logic [7:0] sr;
   logic [3:0] bit_cnt;
   logic       out_bit, done;

   function automatic logic hit(input logic [2:0] ofs);
      hit = (bus_i.addr == ofs);
   endfunction

   assign is_master = en_ff && ((mode_ff <= SSP_MODE_TMR2) || (mode_ff == SSP_MODE_BAUD));
   assign is_slave  = en_ff && ((mode_ff == SSP_MODE_SLV_SS) || (mode_ff == SSP_MODE_SLV));
   assign ss_mode   = is_slave && (mode_ff == SSP_MODE_SLV_SS);
   assign slv_act   = is_slave && !(ss_mode && ss_n_i);
   assign busy      = (mst_ff == SSP_MS_RUN) || (is_slave && bit_cnt != 4'h0);

   assign wr_buf  = ce_i && bus_i.wr && hit(SSP_OFS_BUF);
   assign rd_buf  = ce_i && bus_i.rd && hit(SSP_OFS_BUF);
   assign accept  = wr_buf && !busy && !write_collision_flag_ff;
   assign collide = wr_buf && busy;

   // ----------------------------------------------------------------
   // master clocking
   // ----------------------------------------------------------------
   // the rate counter holds while asleep, so a transfer resumes mid-bit
   ssp_rate_gen u_rate (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .ce_i        (ce_i && !sleep_i),
      .run_i       ((mst_ff == SSP_MS_RUN) && !sleep_i),
      .mode_i      (mode_ff),
      .baud_i      (baud_ff),
      .tmr2_tick_i (tmr2_tick_i),
      .tick_o      (tick)
   );

   assign lead_m  = tick && !edge_ff[0];
   assign trail_m = tick && edge_ff[0];

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mst_ff  <= SSP_MS_IDLE;
         edge_ff <= 4'h0;
      end else if (ce_i) begin
         case (mst_ff)
            SSP_MS_IDLE: begin
               edge_ff <= 4'h0;
               if (accept && is_master)
                  mst_ff <= SSP_MS_RUN;
            end
            SSP_MS_RUN: begin
               if (!is_master)
                  mst_ff <= SSP_MS_IDLE;
               else if (tick) begin
                  edge_ff <= edge_ff + 4'h1;
                  if (edge_ff == SSP_EDGES)
                     mst_ff <= SSP_MS_IDLE;
               end
            end
            default: mst_ff <= SSP_MS_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         sck_o <= 1'b0;
      else if (ce_i) begin
         if (mst_ff == SSP_MS_IDLE || !is_master)
            sck_o <= ckp_ff;
         else if (tick)
            sck_o <= !sck_o;
      end
   end

   // ----------------------------------------------------------------
   // slave edge detection
   // ----------------------------------------------------------------
   // the leading edge is the one leaving the idle level; a clock that is not
   // idle when the port is enabled would misalign the byte
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         sck_prev_ff <= 1'b0;
      else if (ce_i)
         sck_prev_ff <= sck_i;
   end

   // sleep does not gate the slave path: the external clock drives it
   assign lead_s  = slv_act && (sck_i != sck_prev_ff) && (sck_prev_ff == ckp_ff);
   assign trail_s = slv_act && (sck_i != sck_prev_ff) && (sck_prev_ff != ckp_ff);
   assign lead    = lead_m || lead_s;
   assign trail   = trail_m || trail_s;

   // edge select set: bit already out, sample leading, drive trailing;
   // sample phase is not used to move the sampling point
   assign do_sample = cke_ff ? lead : trail;
   assign do_drive  = cke_ff ? trail : lead;
   assign port_clr  = !en_ff || (ss_mode && ss_n_i);

   // the input is sampled whether or not anything listens to the output
   ssp_shifter u_shift (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .clr_i     (port_clr),
      .load_i    (accept),
      .ld_data_i (bus_i.wdata),
      .drive_i   (do_drive),
      .sample_i  (do_sample),
      .sdi_i     (sdi_i),
      .sr_o      (sr),
      .out_o     (out_bit),
      .cnt_o     (bit_cnt),
      .done_o    (done)
   );

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   assign sck_oe_o = is_master;
   assign sdo_o    = out_bit;
   // without select control the slave output never floats
   assign sdo_oe_o = is_master || (is_slave && !(ss_mode && ss_n_i));

   // ----------------------------------------------------------------
   // receive buffer and flags
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         buf_ff <= SSP_RST_BYTE;
      else if (ce_i) begin
         // the last bit enters the shifter on this same edge: take it from the pin
         if (done && (!bf_ff || buffer_overwrite_enable_ff))
            buf_ff <= {sr[6:0], sdi_i};
         else if (accept)
            buf_ff <= bus_i.wdata;
      end
   end

   // every set below beats a same-cycle clear so no event is lost
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         bf_ff <= 1'b0;
      else if (ce_i) begin
         if (done)
            bf_ff <= 1'b1;
         else if (rd_buf)
            bf_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i)
         flag_ff <= 1'b0;
      else if (ce_i) begin
         if (done)
            flag_ff <= 1'b1;
         else if (bus_i.wr && hit(SSP_OFS_PERIPHERAL_IRQ_FLAGS_ONE))
            flag_ff <= bus_i.wdata[SSP_PIR_FLAG];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         write_collision_flag_ff <= 1'b0;
         ov_ff   <= 1'b0;
      end else if (ce_i) begin
         if (collide)
            write_collision_flag_ff <= 1'b1;
         else if (bus_i.wr && hit(SSP_OFS_CON1))
            write_collision_flag_ff <= bus_i.wdata[SSP_CON1_WRITE_COLLISION_FLAG];
         if (done && bf_ff)
            ov_ff <= 1'b1;
         else if (bus_i.wr && hit(SSP_OFS_CON1))
            ov_ff <= bus_i.wdata[SSP_CON1_OV];
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         en_ff   <= 1'b0;
         ckp_ff  <= 1'b0;
         mode_ff <= SSP_MODE_DIV4;
         con3_ff <= SSP_RST_BYTE;
         smp_ff  <= 1'b0;
         cke_ff  <= 1'b0;
         ie_ff   <= 1'b0;
         baud_ff <= SSP_RST_BYTE;
      end else if (ce_i && bus_i.wr) begin
         if (hit(SSP_OFS_CON1)) begin
            en_ff   <= bus_i.wdata[SSP_CON1_EN];
            ckp_ff  <= bus_i.wdata[SSP_CON1_CKP];
            mode_ff <= bus_i.wdata[3:0];
         end else if (hit(SSP_OFS_CON3))
            con3_ff <= bus_i.wdata;
         else if (hit(SSP_OFS_STAT)) begin
            smp_ff <= bus_i.wdata[SSP_STAT_SMP];
            cke_ff <= bus_i.wdata[SSP_STAT_CKE];
         end else if (hit(SSP_OFS_PERIPHERAL_IRQ_ENABLE_ONE))
            ie_ff <= bus_i.wdata[SSP_PIE_EN];
         else if (hit(SSP_OFS_BAUD))
            baud_ff <= bus_i.wdata;
      end
   end

   assign buffer_overwrite_enable_ff = con3_ff[SSP_CON3_BUFFER_OVERWRITE_ENABLE];

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         rdata_o <= SSP_RST_BYTE;
      else if (ce_i) begin
         if (!bus_i.rd)
            rdata_o <= SSP_RST_BYTE;
         else if (hit(SSP_OFS_BUF))
            rdata_o <= buf_ff;
         else if (hit(SSP_OFS_CON1))
            rdata_o <= {write_collision_flag_ff, ov_ff, en_ff, ckp_ff, mode_ff};
         else if (hit(SSP_OFS_CON3))
            rdata_o <= con3_ff;
         else if (hit(SSP_OFS_STAT))
            rdata_o <= {smp_ff, cke_ff, 5'h00, bf_ff};
         else if (hit(SSP_OFS_PERIPHERAL_IRQ_ENABLE_ONE))
            rdata_o <= {4'h0, ie_ff, 3'h0};
         else if (hit(SSP_OFS_PERIPHERAL_IRQ_FLAGS_ONE))
            rdata_o <= {4'h0, flag_ff, 3'h0};
         else if (hit(SSP_OFS_BAUD))
            rdata_o <= baud_ff;
         else
            rdata_o <= SSP_RST_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // wake and interrupt
   // ----------------------------------------------------------------
   // a master cannot wake from sleep: its own clock is stopped
   assign port_irq_o = flag_ff && ie_ff;
   assign wake_o     = port_irq_o && (idle_i || (sleep_i && is_slave));

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   sequence m_start_s;
      ce_i && accept && is_master;
   endsequence
   sequence m_running_s;
      mst_ff == SSP_MS_RUN;
   endsequence

   master_start_a: assert property (m_start_s |=> m_running_s)
      else $error("master write did not start a transfer");
   msb_first_a: assert property (ce_i && accept |=> sdo_o == $past(bus_i.wdata[7]))
      else $error("first output bit is not the msb");
   early_data_a: assert property (ce_i && accept && cke_ff |=> sdo_o == buf_ff[7])
      else $error("data not valid before first edge");
   write_collision_flag_set_a: assert property (collide |=> write_collision_flag_ff && buf_ff == $past(buf_ff))
      else $error("collision not flagged or write not ignored");
   bf_set_a: assert property (ce_i && done |=> bf_ff && flag_ff)
      else $error("received byte did not set full and flag");
   overwrite_a: assert property (ce_i && done && bf_ff && buffer_overwrite_enable_ff |=>
      buf_ff == sr && ov_ff)
      else $error("overwrite did not load the new byte");
   ss_release_a: assert property (ss_mode && ss_n_i |-> !sdo_oe_o)
      else $error("output driven while deselected");
   ss_reset_a: assert property (ce_i && ss_mode && ss_n_i |=> bit_cnt == 4'h0)
      else $error("deselect did not clear the bit counter");
   disable_clear_a: assert property (ce_i && !en_ff |=> bit_cnt == 4'h0 && mst_ff == SSP_MS_IDLE)
      else $error("disable did not reset the port");
   sleep_freeze_a: assert property (m_running_s ##0 (sleep_i && ce_i)[*2] |-> $stable(sck_o))
      else $error("master clock moved during sleep");
   slave_drive_a: assert property (is_slave && !ss_mode |-> sdo_oe_o)
      else $error("plain slave output not driven");
   wake_idle_a: assert property (flag_ff && ie_ff && idle_i |-> wake_o)
      else $error("enabled flag did not wake from idle");
endmodule // ssp_spi_port

// ==== tb/ssp_far_end.sv ====
// far-end slave model for master-mode transfers of the spi port
// assumes clock polarity low and data valid before the first edge
`timescale 1ns/1ps
module ssp_far_end (
   input  wire logic       sck_i,  // serial clock line
   input  wire logic       din_i,  // data from the port
   input  wire logic       load_i, // arm with reply byte
   input  wire logic [7:0] tx_i,   // reply byte
   output logic            dout_o, // data to the port
   output logic [7:0]      rx_o    // captured byte
);
   logic [7:0] sh;
   int         n;
   initial begin
      dout_o = 1'b0;
      rx_o = 8'h00;
   end
   always @(posedge load_i) begin
      sh = tx_i;
      dout_o = tx_i[7];
      n = 0;
   end
   always @(posedge sck_i) begin
      rx_o = {rx_o[6:0], din_i};
      n++;
   end
   always @(negedge sck_i) begin
      sh = sh << 1;
      // past the byte the line is no longer held, so it wanders
      dout_o = (n < 8) ? sh[7] : ~dout_o;
   end
endmodule // ssp_far_end

// ==== tb/tb_ssp_spi_port.sv ====
// self-checking bench: master transfer with collision, selected slave with abort
// assumes the far-end model is compiled before this file
`timescale 1ns/1ps
module tb_ssp_spi_port;
   import ssp_pkg::*;
   logic         mclk_i, reset_i, sleep_i, idle_i, sck_d, sdi_d, ss_n_i, slv, ld;
   logic         sck_o, sck_oe_o, sdo_o, sdo_oe_o, port_irq_o, wake_o, miso;
   logic         sck_w, sdo_w;
   logic [7:0]   rdata_o, rx, q;
   ssp_bus_req_t bus;
   int           err_total, samples_checked;
   assign sck_w = sck_oe_o ? sck_o : sck_d;
   assign sdo_w = sdo_oe_o ? sdo_o : 1'b1; // pulled up when released
   ssp_spi_port ssp_spi_port_i (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1),
      .bus_i(bus), .rdata_o(rdata_o), .sleep_i(sleep_i), .idle_i(idle_i),
      .tmr2_tick_i(1'b0), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
      .sdi_i(slv ? sdi_d : miso), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .ss_n_i(ss_n_i), .port_irq_o(port_irq_o), .wake_o(wake_o));
   ssp_far_end ssp_far_end_i (.sck_i(sck_w), .din_i(sdo_w), .load_i(ld),
      .tx_i(8'h3c), .dout_o(miso), .rx_o(rx));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one register cycle; read data captured once the answer edge has landed
   task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic w);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge mclk_i);
      bus <= '0;
      #1 q = rdata_o;
      @(posedge mclk_i);
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 400 && port_irq_o !== 1'b1; i++) @(posedge mclk_i);
      chk({7'h0, port_irq_o}, 8'h01);
   endtask
   // serial clock kept slow: four system cycles per level
   task automatic sbits(input logic [7:0] din, input logic [7:0] dexp, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sdi_d <= din[i];
         sck_d <= 1'b1;
         repeat (4) @(posedge mclk_i);
         chk({7'h0, sdo_w}, {7'h0, dexp[i]});
         sck_d <= 1'b0;
         repeat (4) @(posedge mclk_i);
      end
   endtask
   task automatic master_xfer;
      acc(SSP_OFS_PERIPHERAL_IRQ_ENABLE_ONE, 8'h08, 1'b1);
      acc(SSP_OFS_STAT, 8'h40, 1'b1);
      acc(SSP_OFS_CON1, 8'h20, 1'b1);
      ld <= 1'b1;
      acc(SSP_OFS_BUF, 8'ha5, 1'b1);
      acc(SSP_OFS_BUF, 8'h11, 1'b1);
      // asleep longer than a whole byte takes: nothing may finish meanwhile
      sleep_i <= 1'b1;
      repeat (40) @(posedge mclk_i);
      chk({7'h0, port_irq_o}, 8'h00);
      sleep_i <= 1'b0;
      wait_irq();
      sleep_i <= 1'b1;
      @(posedge mclk_i);
      chk({7'h0, wake_o}, 8'h00);
      sleep_i <= 1'b0;
      idle_i <= 1'b1;
      @(posedge mclk_i);
      chk({7'h0, wake_o}, 8'h01);
      idle_i <= 1'b0;
      chk(rx, 8'ha5);
      acc(SSP_OFS_STAT, 8'h00, 1'b0);
      chk(q, 8'h41);
      acc(SSP_OFS_BUF, 8'h00, 1'b0);
      chk(q, 8'h3c);
      acc(SSP_OFS_STAT, 8'h00, 1'b0);
      chk(q, 8'h40);
      acc(SSP_OFS_CON1, 8'h00, 1'b0);
      chk(q, 8'ha0);
      acc(SSP_OFS_BUF, 8'h77, 1'b1);
      acc(SSP_OFS_BUF, 8'h00, 1'b0);
      chk(q, 8'h3c);
      acc(3'h7, 8'hff, 1'b1);
      acc(3'h7, 8'h00, 1'b0);
      chk(q, 8'h00);
      // baud divider 1: serial clock of 8 system clocks, done near cycle 60
      acc(SSP_OFS_PERIPHERAL_IRQ_FLAGS_ONE, 8'h00, 1'b1);
      acc(SSP_OFS_BAUD, 8'h01, 1'b1);
      acc(SSP_OFS_CON1, 8'h2a, 1'b1);
      acc(SSP_OFS_BUF, 8'h69, 1'b1);
      repeat (50) @(posedge mclk_i);
      chk({7'h0, port_irq_o}, 8'h00);
      repeat (14) @(posedge mclk_i);
      chk({7'h0, port_irq_o}, 8'h01);
      chk(rx, 8'h69);
      acc(SSP_OFS_BUF, 8'h00, 1'b0);
   endtask
   task automatic slave_xfer;
      slv <= 1'b1;
      acc(SSP_OFS_PERIPHERAL_IRQ_FLAGS_ONE, 8'h00, 1'b1);
      acc(SSP_OFS_STAT, 8'h00, 1'b1);
      acc(SSP_OFS_CON1, 8'h24, 1'b1);
      acc(SSP_OFS_BUF, 8'h96, 1'b1);
      ss_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk({7'h0, sdo_oe_o}, 8'h01);
      sbits(8'h00, 8'h96, 3);
      ss_n_i <= 1'b1;
      sdi_d <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk({7'h0, sdo_oe_o}, 8'h00);
      acc(SSP_OFS_BUF, 8'h96, 1'b1);
      acc(SSP_OFS_CON1, 8'h00, 1'b0);
      chk(q, 8'h24);
      ss_n_i <= 1'b0;
      sleep_i <= 1'b1;
      sbits(8'h5a, 8'h96, 8);
      wait_irq();
      chk({7'h0, wake_o}, 8'h01);
      sleep_i <= 1'b0;
      acc(SSP_OFS_BUF, 8'h00, 1'b0);
      chk(q, 8'h5a);
      // next byte left unread, then one more with overwrite enabled
      sbits(8'hc3, 8'h5a, 8);
      acc(SSP_OFS_CON3, 8'h10, 1'b1);
      sbits(8'h3c, 8'hc3, 8);
      acc(SSP_OFS_BUF, 8'h00, 1'b0);
      chk(q, 8'h3c);
      acc(SSP_OFS_CON1, 8'h00, 1'b0);
      chk(q, 8'h64);
   endtask
   task automatic complete_run;
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
   initial begin
      err_total = 0;
      samples_checked = 0;
      reset_i = 1'b1;
      bus = '0;
      sleep_i = 1'b0;
      idle_i = 1'b0;
      sck_d = 1'b0;
      sdi_d = 1'b0;
      ss_n_i = 1'b1;
      slv = 1'b0;
      ld = 1'b0;
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      master_xfer();
      slave_xfer();
      complete_run();
   end
endmodule // tb_ssp_spi_port
